// ===== ssc_apb_slave.sv
// Purpose: APB slave front end with one registered answer per transfer
// Assumes: master keeps the request stable through the access phase
// Notes: pready rises in the first access cycle, so no wait states
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_apb_slave (
	// clock and reset
	input  wire logic                  clock_in,
	input  wire logic                  rst_n_in,
	input  wire logic                  ce_in,
	// bus side
	input  wire ssc_pkg::ssc_apb_req_s req_in,
	output ssc_pkg::ssc_apb_rsp_s      rsp_out,
	// bank side
	input  wire logic [31:0]           rdata_in,
	input  wire logic                  hit_in,
	output logic                       wr_out,
	output logic [5:0]                 idx_out
);
	ssc_pkg::ssc_apb_rsp_s next_rsp;
	logic                  setup;

	assign idx_out = req_in.addr[7:2];
	assign setup   = req_in.sel && !req_in.enable && !rsp_out.ready;
	// write lands only on the edge where the master sees pready
	assign wr_out  = ce_in && req_in.sel && req_in.enable && rsp_out.ready
		&& req_in.write && hit_in;

	always_comb begin
		next_rsp = rsp_out;
		if (setup) begin
			next_rsp.ready  = 1'b1;
			next_rsp.rdata  = hit_in ? rdata_in : 32'h00000000;
			next_rsp.slverr = !hit_in;
		end else begin
			next_rsp.ready  = 1'b0;
			next_rsp.slverr = 1'b0;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rsp_out <= '0;
		end else if (ce_in) begin
			rsp_out <= next_rsp;
		end
	end
endmodule

// ===== ssc_config_bank.sv
// Purpose: soft slicer configuration bank with APB access and slicer lookup
// Assumes: single clock, slicer asks one index per lookup_req_in cycle
// Notes: lookup answers one cycle after the request
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_config_bank (
	// clock and reset
	input  wire logic        clock_in,
	input  wire logic        rst_n_in,
	input  wire logic        ce_in,
	// apb slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic             pready_out,
	output logic [31:0]      prdata_out,
	output logic             pslverr_out,
	// slicer lookup
	input  wire logic        lookup_req_in,
	input  wire logic [3:0]  lookup_index_in,
	output logic [31:0]      factor_out,
	output logic             factor_valid_out,
	output logic [15:0]      unit_value_out,
	output logic [11:0]      symbol_count_out,
	output logic             unit_valid_out,
	// mode view
	output logic [3:0]       segment_count_out,
	output logic [4:0]       mode_out
);
	ssc_pkg::ssc_apb_req_s bus_req;
	ssc_pkg::ssc_apb_rsp_s bus_rsp;
	logic                  wr;
	logic [5:0]            idx;
	logic                  hit;
	logic [31:0]           rdata;

	logic [31:0]           bank      [`SSC_BANK_WORDS];
	logic [31:0]           next_bank [`SSC_BANK_WORDS];
	ssc_pkg::ssc_noise_t   noise;
	logic [31:0]           ctrl;
	logic [31:0]           next_ctrl;

	ssc_pkg::ssc_mode_e    mode;
	ssc_pkg::ssc_mode_e    next_mode;
	logic [3:0]            seg_count;
	logic [3:0]            next_seg_count;

	logic [31:0]           sel_factor;
	logic                  sel_valid;
	logic [31:0]           next_factor;
	logic                  next_factor_valid;
	logic [15:0]           next_unit;
	logic [11:0]           next_count;
	logic                  next_unit_valid;
	logic [31:0]           fdd_word;

	assign bus_req = '{sel: psel_in, enable: penable_in, write: pwrite_in,
		addr: paddr_in, wdata: pwdata_in};
	assign pready_out  = bus_rsp.ready;
	assign prdata_out  = bus_rsp.rdata;
	assign pslverr_out = bus_rsp.slverr;
	assign hit = idx <= `SSC_IDX_STATUS;

	ssc_apb_slave u_apb (
		.clock_in (clock_in),
		.rst_n_in (rst_n_in),
		.ce_in    (ce_in),
		.req_in   (bus_req),
		.rsp_out  (bus_rsp),
		.rdata_in (rdata),
		.hit_in   (hit),
		.wr_out   (wr),
		.idx_out  (idx)
	);

	// register write paths, one per bank word
	genvar gi;
	generate
		for (gi = 0; gi < `SSC_BANK_WORDS; gi++) begin : g_word
			if (gi < `SSC_TDD_WORDS) begin : g_tdd
				logic [11:0] cnt;
				// oversize counts are clamped rather than wrapped
				assign cnt = (pwdata_in[`SSC_CNT_HI:0] > `SSC_CNT_MAX)
					? `SSC_CNT_MAX : pwdata_in[`SSC_CNT_HI:0];
				assign next_bank[gi] = (wr && idx == 6'(gi))
					? {pwdata_in[`SSC_UV_HI:`SSC_UV_LO], `SSC_RSVD_TDD, cnt}
					: bank[gi];
			end else begin : g_full
				assign next_bank[gi] = (wr && idx == 6'(gi))
					? pwdata_in : bank[gi];
			end
			if (gi >= `SSC_IDX_NOISE0) begin : g_noise
				assign noise[gi - `SSC_IDX_NOISE0] = bank[gi];
			end
		end
	endgenerate

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < `SSC_BANK_WORDS; i++) begin
				bank[i] <= 32'h00000000;
			end
		end else if (ce_in) begin
			for (int i = 0; i < `SSC_BANK_WORDS; i++) begin
				bank[i] <= next_bank[i];
			end
		end
	end

	// control word and derived mode
	always_comb begin
		next_ctrl = ctrl;
		if (wr && idx == `SSC_IDX_CTRL) begin
			next_ctrl = pwdata_in & `SSC_CTRL_MASK;
		end
		case (ctrl[`SSC_CTRL_STD_HI:0])
			`SSC_STD_LTE:   next_mode = ctrl[`SSC_CTRL_SPLIT]
				? ssc_pkg::SSC_MODE_LTE2 : ssc_pkg::SSC_MODE_LTE1;
			`SSC_STD_WIMAX: next_mode = ssc_pkg::SSC_MODE_WIMAX;
			`SSC_STD_WCDMA: next_mode = ctrl[`SSC_CTRL_DUPLEX]
				? ssc_pkg::SSC_MODE_TDD : ssc_pkg::SSC_MODE_FDD;
			default:        next_mode = ssc_pkg::SSC_MODE_WIMAX;
		endcase
		// four channels double the segment count
		if (ctrl[`SSC_CTRL_TTI2MS]) begin
			next_seg_count = (ctrl[`SSC_CTRL_NPC_HI:`SSC_CTRL_NPC_LO] == `SSC_NPC_FOUR)
				? `SSC_SEG_2MS_NPC4 : `SSC_SEG_2MS;
		end else begin
			next_seg_count = (ctrl[`SSC_CTRL_NPC_HI:`SSC_CTRL_NPC_LO] == `SSC_NPC_FOUR)
				? `SSC_SEG_10MS_NPC4 : `SSC_SEG_10MS;
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ctrl      <= `SSC_CTRL_RESET;
			mode      <= ssc_pkg::SSC_MODE_LTE1;
			seg_count <= `SSC_SEG_10MS;
		end else if (ce_in) begin
			ctrl      <= next_ctrl;
			mode      <= next_mode;
			seg_count <= next_seg_count;
		end
	end

	// read mux; status shows the live mode and segment count
	always_comb begin
		rdata = 32'h00000000;
		if (idx < `SSC_BANK_WORDS) begin
			rdata = bank[idx[4:0]];
		end else if (idx == `SSC_IDX_CTRL) begin
			rdata = ctrl;
		end else if (idx == `SSC_IDX_STATUS) begin
			rdata[4:0] = mode;
			rdata[`SSC_STATUS_SEG_LO +: 4] = seg_count;
		end
	end

	ssc_factor_select u_sel (
		.mode_in      (mode),
		.seg_count_in (seg_count),
		.index_in     (lookup_index_in),
		.noise_in     (noise),
		.factor_out   (sel_factor),
		.valid_out    (sel_valid)
	);

	// unit value lookup; only tdd slots 4 and 5 live in this bank
	assign fdd_word = bank[5'(`SSC_IDX_FDD0) + 5'(lookup_index_in[3:1])];

	always_comb begin
		next_factor       = factor_out;
		next_factor_valid = factor_valid_out;
		next_unit         = unit_value_out;
		next_count        = symbol_count_out;
		next_unit_valid   = unit_valid_out;
		if (lookup_req_in) begin
			next_factor       = sel_factor;
			next_factor_valid = sel_valid;
			next_unit         = 16'h0000;
			next_count        = 12'h000;
			next_unit_valid   = 1'b0;
			if (mode == ssc_pkg::SSC_MODE_TDD
				&& lookup_index_in >= `SSC_TDD_BANK_SLOT
				&& lookup_index_in <= `SSC_TDD_LAST_SLOT) begin
				next_unit = bank[5'(lookup_index_in[0])][`SSC_UV_HI:`SSC_UV_LO];
				next_count = bank[5'(lookup_index_in[0])][`SSC_CNT_HI:0];
				next_unit_valid = 1'b1;
			end else if (mode == ssc_pkg::SSC_MODE_FDD
				&& lookup_index_in <= `SSC_FDD_LAST_SLOT) begin
				next_unit = lookup_index_in[0] ? fdd_word[`SSC_ODD_HI:0]
					: fdd_word[`SSC_UV_HI:`SSC_UV_LO];
				next_unit_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			factor_out        <= 32'h00000000;
			factor_valid_out  <= 1'b0;
			unit_value_out    <= 16'h0000;
			symbol_count_out  <= 12'h000;
			unit_valid_out    <= 1'b0;
			segment_count_out <= `SSC_SEG_10MS;
			mode_out          <= ssc_pkg::SSC_MODE_LTE1;
		end else if (ce_in) begin
			factor_out        <= next_factor;
			factor_valid_out  <= next_factor_valid;
			unit_value_out    <= next_unit;
			symbol_count_out  <= next_count;
			unit_valid_out    <= next_unit_valid;
			segment_count_out <= next_seg_count;
			mode_out          <= next_mode;
		end
	end

	// checks
	logic [31:0] chk_col_word;
	assign chk_col_word = (lookup_index_in <= `SSC_LAST_COLUMN)
		? noise[lookup_index_in] : 32'h00000000;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_ask(ssc_pkg::ssc_mode_e m);
		ce_in && lookup_req_in && mode == m;
	endsequence
	sequence s_answer;
		ce_in ##0 factor_valid_out;
	endsequence

	chk_tdd_reserved: assert property (
		bank[0][15:12] == 4'h0 && bank[1][15:12] == 4'h0
		&& bank[0][11:0] <= 12'hBF8 && bank[1][11:0] <= 12'hBF8)
		else $error("tdd reserved or count field out of bounds");
	chk_fdd_word_kept: assert property (
		wr && idx >= 6'h02 && idx <= 6'h07 |=> bank[$past(idx[4:0])] == $past(pwdata_in))
		else $error("fdd pair word not stored as written");
	chk_noise_word: assert property (
		wr && idx >= 6'h08 && idx <= 6'h10 |=> bank[$past(idx[4:0])] == $past(pwdata_in))
		else $error("noise word not stored whole");
	chk_lte_single_map: assert property (
		s_ask(ssc_pkg::SSC_MODE_LTE1) and lookup_index_in <= 4'h8
		|=> factor_valid_out && factor_out == $past(chk_col_word))
		else $error("lte single column factor mismatch");
	chk_lte_split_map: assert property (
		s_ask(ssc_pkg::SSC_MODE_LTE2) and lookup_index_in <= 4'h8
		|=> factor_valid_out && factor_out == $past(chk_col_word))
		else $error("lte split layer0 factor mismatch");
	chk_tdd_ignore_high: assert property (
		s_ask(ssc_pkg::SSC_MODE_TDD) and lookup_index_in >= 4'h6
		|=> !factor_valid_out && factor_out == 32'h00000000)
		else $error("tdd used a factor beyond slot 5");
	chk_wimax_unused: assert property (
		s_ask(ssc_pkg::SSC_MODE_WIMAX) |=> not s_answer)
		else $error("wimax returned a noise factor");
	chk_fdd_segment: assert property (
		s_ask(ssc_pkg::SSC_MODE_FDD)
		|=> factor_valid_out == ($past(lookup_index_in) < $past(seg_count)
			&& $past(lookup_index_in) <= 4'h8))
		else $error("fdd segment validity wrong");
	chk_duplex_select: assert property (
		ce_in && ctrl[1:0] == 2'h2
		|=> mode == ($past(ctrl[2]) ? ssc_pkg::SSC_MODE_TDD : ssc_pkg::SSC_MODE_FDD))
		else $error("duplex bit did not select mode");
	chk_seg_count: assert property (
		ce_in |=> seg_count inside {4'h5, 4'h6, 4'hA, 4'hC})
		else $error("illegal fdd segment count");
	chk_retain: assert property (
		!wr |=> bank[8] == $past(bank[8]) && bank[2] == $past(bank[2]))
		else $error("register changed without a write");
	chk_freeze_bank: assert property (
		!ce_in |=> bank[0] == $past(bank[0]) && bank[16] == $past(bank[16])
			&& ctrl == $past(ctrl))
		else $error("state moved while clock enable was low");
	chk_freeze_answer: assert property (
		!ce_in |=> factor_out == $past(factor_out)
			&& factor_valid_out == $past(factor_valid_out))
		else $error("lookup answer moved while clock enable was low");
	chk_unit_tdd: assert property (
		s_ask(ssc_pkg::SSC_MODE_TDD) and lookup_index_in == `SSC_TDD_BANK_SLOT
		|=> unit_valid_out && unit_value_out == $past(bank[0][`SSC_UV_HI:`SSC_UV_LO])
			&& symbol_count_out == $past(bank[0][`SSC_CNT_HI:0]))
		else $error("tdd slot unit value or count not from its word");
	chk_unit_fdd_odd: assert property (
		s_ask(ssc_pkg::SSC_MODE_FDD) and lookup_index_in == 4'h3
		|=> unit_valid_out && unit_value_out == $past(bank[3][`SSC_ODD_HI:0]))
		else $error("odd fdd slot not taken from low half");
endmodule

// ===== ssc_factor_select.sv
// Purpose: picks the noise scaling word for a column, slot or segment
// Assumes: caller registers the result
// Notes: purely combinational
`timescale 1ns/1ps
`include "ssc_regs.svh"
module ssc_factor_select (
	// selection
	input  wire ssc_pkg::ssc_mode_e  mode_in,
	input  wire logic [3:0]          seg_count_in,
	input  wire logic [3:0]          index_in,
	input  wire ssc_pkg::ssc_noise_t noise_in,
	// result
	output logic [31:0]              factor_out,
	output logic                     valid_out
);
	logic in_bank;

	assign in_bank = index_in <= `SSC_LAST_COLUMN;

	always_comb begin
		factor_out = in_bank ? noise_in[index_in] : 32'h00000000;
		case (mode_in)
			ssc_pkg::SSC_MODE_LTE1:  valid_out = in_bank;
			ssc_pkg::SSC_MODE_LTE2:  valid_out = in_bank;
			ssc_pkg::SSC_MODE_TDD:   valid_out = index_in <= `SSC_TDD_LAST_SLOT;
			ssc_pkg::SSC_MODE_FDD:   valid_out = in_bank && index_in < seg_count_in;
			ssc_pkg::SSC_MODE_WIMAX: valid_out = 1'b0;
			default:                 valid_out = 1'b0;
		endcase
		if (!valid_out) begin
			factor_out = 32'h00000000;
		end
	end
endmodule

// ===== ssc_pkg.sv
// Purpose: shared types of the soft slicer config bank
// Assumes: constants live in ssc_regs.svh
// Notes: mode codes are one-hot
package ssc_pkg;

	typedef enum logic [4:0] {
		SSC_MODE_LTE1  = 5'b00001,
		SSC_MODE_LTE2  = 5'b00010,
		SSC_MODE_TDD   = 5'b00100,
		SSC_MODE_FDD   = 5'b01000,
		SSC_MODE_WIMAX = 5'b10000
	} ssc_mode_e;

	typedef struct packed {
		logic        sel;
		logic        enable;
		logic        write;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} ssc_apb_req_s;

	typedef struct packed {
		logic        ready;
		logic [31:0] rdata;
		logic        slverr;
	} ssc_apb_rsp_s;

	typedef logic [8:0][31:0] ssc_noise_t;

endpackage

// ===== ssc_regs.svh
// Purpose: register map and field constants of the soft slicer config bank
// Assumes: 32-bit APB, one aligned word per register, byte address = index * 4
// Notes: index constants are word indices into the bank
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

`define SSC_IDX_TDD4       6'h00
`define SSC_IDX_TDD5       6'h01
`define SSC_IDX_FDD0       6'h02
`define SSC_IDX_NOISE0     6'h08
`define SSC_IDX_CTRL       6'h11
`define SSC_IDX_STATUS     6'h12
`define SSC_BANK_WORDS     17
`define SSC_TDD_WORDS      2
`define SSC_NOISE_WORDS    9

`define SSC_UV_HI          31
`define SSC_UV_LO          16
`define SSC_ODD_HI         15
`define SSC_CNT_HI         11
`define SSC_CNT_MAX        12'hBF8
`define SSC_RSVD_TDD       4'h0

`define SSC_CTRL_STD_HI    1
`define SSC_CTRL_DUPLEX    2
`define SSC_CTRL_SPLIT     3
`define SSC_CTRL_TTI2MS    4
`define SSC_CTRL_NPC_HI    6
`define SSC_CTRL_NPC_LO    5
`define SSC_CTRL_MASK      32'h0000007F
`define SSC_CTRL_RESET     32'h00000000

`define SSC_STD_LTE        2'h0
`define SSC_STD_WIMAX      2'h1
`define SSC_STD_WCDMA      2'h2
`define SSC_NPC_FOUR       2'h2

`define SSC_SEG_10MS       4'h5
`define SSC_SEG_10MS_NPC4  4'hA
`define SSC_SEG_2MS        4'h6
`define SSC_SEG_2MS_NPC4   4'hC

`define SSC_TDD_LAST_SLOT  4'h5
`define SSC_TDD_BANK_SLOT  4'h4
`define SSC_FDD_LAST_SLOT  4'hB
`define SSC_LAST_COLUMN    4'h8
`define SSC_STATUS_SEG_LO  8

`endif

// ===== tb.sv
// Purpose: self-checking bench for the soft slicer config bank
// Assumes: byte address = word index * 4, apb answer without wait states
// Notes: expectations come from bench functions and a shadow of the bank
`timescale 1ns/1ps
`include "ssc_regs.svh"
module tb;
	logic             clk;
	logic             rst_n;
	logic             ce;
	logic             psel;
	logic             penable;
	logic             pwrite;
	logic             req;
	logic [7:0]       paddr;
	logic [31:0]      pwdata;
	logic [31:0]      rd;
	logic             err;
	logic [3:0]       idx;
	logic [31:0]      bank [17];
	wire logic        pready;
	wire logic        pslverr;
	wire logic        fvalid;
	wire logic        uvalid;
	wire logic [31:0] prdata;
	wire logic [31:0] factor;
	wire logic [15:0] uval;
	wire logic [11:0] scount;
	wire logic [3:0]  segs;
	wire logic [4:0]  mode;
	int               error_cnt = 0;
	int               n_checks = 0;

	ssc_config_bank ssc_config_bank_i (
		.clock_in(clk), .rst_n_in(rst_n), .ce_in(ce),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr),
		.lookup_req_in(req), .lookup_index_in(idx), .factor_out(factor),
		.factor_valid_out(fvalid), .unit_value_out(uval), .symbol_count_out(scount),
		.unit_valid_out(uvalid), .segment_count_out(segs), .mode_out(mode)
	);

	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [5:0] i, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= {i, 2'h0};
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		while (pready !== 1'h1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n >= 20)
			chk(32'h0, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	function automatic logic [31:0] tdd_exp(input logic [31:0] d);
		logic [11:0] c;
		c = (d[11:0] > 12'hBF8) ? 12'hBF8 : d[11:0];
		return {d[31:16], 4'h0, c};
	endfunction

	function automatic logic [4:0] mode_exp(input logic [6:0] c);
		case (c[1:0])
			2'h0: return c[3] ? 5'h02 : 5'h01;
			2'h2: return c[2] ? 5'h04 : 5'h08;
			default: return 5'h10;
		endcase
	endfunction

	function automatic logic [3:0] seg_exp(input logic [6:0] c);
		if (c[6:5] == 2'h2)
			return c[4] ? 4'hC : 4'hA;
		return c[4] ? 4'h6 : 4'h5;
	endfunction

	function automatic logic [32:0] fac_exp(input logic [6:0] c, input logic [3:0] i);
		logic ok;
		case (mode_exp(c))
			5'h01, 5'h02: ok = (i <= 4'h8);
			5'h04: ok = (i <= 4'h5);
			5'h08: ok = (i < seg_exp(c)) && (i <= 4'h8);
			default: ok = 1'h0;
		endcase
		return ok ? {1'h1, bank[8 + i]} : 33'h0;
	endfunction

	function automatic logic [28:0] unit_exp(input logic [6:0] c, input logic [3:0] i);
		logic [31:0] w;
		if (mode_exp(c) == 5'h04 && (i == 4'h4 || i == 4'h5)) begin
			w = bank[i - 4];
			return {1'h1, w[31:16], w[11:0]};
		end
		if (mode_exp(c) == 5'h08 && i <= 4'hB) begin
			w = bank[2 + (i >> 1)];
			return {1'h1, i[0] ? w[15:0] : w[31:16], 12'h0};
		end
		return 29'h0;
	endfunction

	task automatic check_bank();
		for (int i = 0; i < 17; i++) begin
			apb(1'h0, 6'(i), 32'h0);
			chk(rd, bank[i]);
		end
	endtask

	// lookups run back to back; the answer to index j-2 is read at edge j
	task automatic lookups(input logic [6:0] c);
		logic [32:0] fe;
		logic [28:0] ue;
		logic [3:0]  k;
		for (int j = 0; j < 18; j++) begin
			@(posedge clk);
			k = 4'(j - 2);
			if (j >= 2) begin
				fe = fac_exp(c, k);
				ue = unit_exp(c, k);
				chk(factor, fe[32] ? bank[8 + k] : 32'h0);
				chk({31'h0, fvalid}, {31'h0, fe[32]});
				chk(factor, fe[31:0]);
				chk({15'h0, uvalid, uval}, {15'h0, ue[28:12]});
				chk({20'h0, scount}, {20'h0, ue[11:0]});
			end
			req <= (j < 16);
			idx <= 4'(j);
		end
	endtask

	initial begin
		logic [6:0]  ctl [10];
		logic [31:0] d;
		ctl = '{7'h00, 7'h08, 7'h06, 7'h02, 7'h12,
			7'h42, 7'h52, 7'h22, 7'h01, 7'h03};
		rst_n = 1'h0;
		ce = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		req = 1'h0;
		idx = 4'h0;
		void'($urandom(32'hd01b));
		foreach (bank[i])
			bank[i] = 32'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'h1;
		check_bank();
		apb(1'h0, `SSC_IDX_STATUS, 32'h0);
		chk(rd, 32'h00000501);
		// random contents, count overflow and count boundary on the slot words
		for (int i = 0; i < 17; i++) begin
			d = $urandom();
			if (i < 2)
				d[31:16] = 16'($urandom_range(4681));
			if (i == 0)
				d[15:0] = 16'hFFFF;
			if (i == 1)
				d[15:0] = 16'hFBF8;
			if (i >= 2 && i < 8)
				d = {16'($urandom_range(10922)), 16'($urandom_range(10922))};
			bank[i] = (i < 2) ? tdd_exp(d) : d;
			apb(1'h1, 6'(i), d);
			chk({31'h0, err}, 32'h0);
		end
		apb(1'h1, 6'h13, 32'hFFFFFFFF);
		chk({31'h0, err}, 32'h1);
		apb(1'h0, 6'h13, 32'h0);
		chk({err, rd[30:0]}, 32'h80000000);
		apb(1'h1, `SSC_IDX_STATUS, 32'hFFFFFFFF);
		check_bank();
		foreach (ctl[m]) begin
			apb(1'h1, `SSC_IDX_CTRL, {25'h1FFFFFF, ctl[m]});
			apb(1'h0, `SSC_IDX_CTRL, 32'h0);
			chk(rd, {25'h0, ctl[m]});
			repeat (2) @(posedge clk);
			chk({27'h0, mode}, {27'h0, mode_exp(ctl[m])});
			chk({28'h0, segs}, {28'h0, seg_exp(ctl[m])});
			lookups(ctl[m]);
		end
		// freeze: a request held while ce is low must not be taken
		apb(1'h1, `SSC_IDX_CTRL, 32'h0);
		@(posedge clk);
		req <= 1'h1;
		idx <= 4'h3;
		@(posedge clk);
		ce <= 1'h0;
		idx <= 4'h5;
		repeat (3) @(posedge clk);
		chk(factor, bank[11]);
		ce <= 1'h1;
		repeat (2) @(posedge clk);
		chk(factor, bank[13]);
		req <= 1'h0;
		check_bank();
		stop_test();
	end

	// the whole sequence needs about 500 cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		stop_test();
	end
endmodule
